// File: inc/cpurf_pkg.sv
// cpurf_pkg: constants and carrier types for the cpu register file and flags block.
// assumes a single 200 MHz system clock and a datapath that issues one request per cycle.
package cpurf_pkg;

	localparam int DATA_W = 8;
	localparam int WORD_W = 16;
	localparam int REG_IDX_W = 3;
	localparam int FLAGS_W = 8;

	// condition_flags field positions
	localparam int FLG_IMASK = 7;
	localparam int FLG_USER1 = 6;
	localparam int FLG_HALF = 5;
	localparam int FLG_USER0 = 4;
	localparam int FLG_NEG = 3;
	localparam int FLG_ZERO = 2;
	localparam int FLG_OVF = 1;
	localparam int FLG_CARRY = 0;

	localparam logic [2:0] STACK_PAIR = 3'h7;
	localparam logic [15:0] RESET_VECTOR_ADDR = 16'h0000;
	localparam logic [7:0] FLAGS_RESET = 8'h80;
	localparam logic [15:0] WORD_EVEN_MASK = 16'hfffe;
	localparam logic [15:0] STACK_STEP = 16'h0002;

	// register add/sub latency: 0.25 us at 8 MHz is two states
	localparam int ADDSUB_NS = 250;
	localparam int REF_CLK_MHZ = 8;
	localparam int ADDSUB_STATES = (ADDSUB_NS * REF_CLK_MHZ) / 1000;

	// alu operation codes
	typedef enum logic [3:0] {
		CPURF_OP_NONE,
		CPURF_OP_ADD,
		CPURF_OP_ADDX,
		CPURF_OP_SUB,
		CPURF_OP_SUBX,
		CPURF_OP_CMP,
		CPURF_OP_NEG,
		CPURF_OP_LOGIC,
		CPURF_OP_SHL,
		CPURF_OP_SHR,
		CPURF_OP_DAA,
		CPURF_OP_DAS,
		CPURF_OP_MOV
	} cpurf_op_type;

	// flag register software operations
	typedef enum logic [2:0] {
		CPURF_FOP_NONE,
		CPURF_FOP_LOAD,
		CPURF_FOP_AND,
		CPURF_FOP_OR,
		CPURF_FOP_XOR
	} cpurf_fop_type;

	// operand size of a register access
	typedef enum logic [1:0] {
		CPURF_SZ_HIGH,
		CPURF_SZ_LOW,
		CPURF_SZ_WORD
	} cpurf_size_type;

	typedef struct packed {
		logic valid;
		cpurf_op_type op;
		cpurf_size_type size;
		logic [2:0] dstIdx;
		logic [2:0] srcIdx;
		cpurf_size_type srcSize;
		logic useImm;
		logic [15:0] imm;
	} cpurf_alu_req_type;

	typedef struct packed {
		logic valid;
		cpurf_size_type size;
		logic [2:0] idx;
		logic [15:0] data;
	} cpurf_wr_req_type;

	typedef struct packed {
		logic branchN;
		logic branchZ;
		logic branchV;
		logic branchC;
	} cpurf_cond_type;

endpackage

// File: hw/cpurf_core.sv
// cpurf_core: general registers, stack pointer, program counter and condition flags.
// assumes requests come from the execution datapath on sys_clk; no bus, ports only.
// alu requests take ADDSUB_STATES cycles; plain writes and flag ops take one.

// Notes on behaviour
// - sixteen byte registers, paired into eight 16-bit registers.
// - pairs readable and writable as word, or as upper or lower byte.
// - address outputs always use the full 16-bit register pair.
// - pair seven doubles as stack pointer, stepped by exception entry and calls.
// - program counter holds next instruction address, bit 0 read as zero.
// - flags loaded, stored, and, or, xor by software instructions.
// - bit 7 masks interrupts; set automatically at exception entry.
// - bits 6 and 4 are user bits holding written values only.
// - byte arithmetic sets half-carry from carry or borrow out of bit 3.
// - word add, subtract, compare set half-carry from bit 11.
// - negative flag copies the result sign bit.
// - zero flag set on zero result, cleared otherwise.
// - overflow flag set on arithmetic overflow, kept by decimal adjust, cleared otherwise.
// - carry records add carry, subtract borrow, or bit shifted out.
// - carry flag is the bit accumulator for bit manipulation.
// - branch conditions come from negative, zero, overflow and carry flags.
// - decimal adjust instructions read the half-carry flag.
// - reset loads counter from vector word at address zero, sets mask.
// - other flags are cleared by reset; general registers are left uninitialised.
// - program counter and addresses cover a 64 kilobyte space.
// - register add or subtract completes in two states.
// - frequent operations complete within two to four states.
module cpurf_core
	import cpurf_pkg::*;
#(
	parameter int LATENCY = ADDSUB_STATES
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// reset vector fetch
	output logic vecReq,
	output logic [15:0] vecAddr,
	input wire logic vecValid,
	input wire logic [15:0] vecData,
	// alu request and answer
	input wire cpurf_alu_req_type aluReq,
	output logic aluBusy,
	output logic aluDone,
	output logic [15:0] aluResult,
	// plain register write and reads
	input wire cpurf_wr_req_type wrReq,
	input wire logic [2:0] rdIdx,
	input wire cpurf_size_type rdSize,
	output logic [15:0] rdData,
	input wire logic [2:0] addrIdx,
	output logic [15:0] addrOut,
	// stack and program counter
	input wire logic excEntry,
	input wire logic subCall,
	input wire logic subRet,
	input wire logic pcLoad,
	input wire logic [15:0] pcLoadVal,
	input wire logic pcStep,
	output logic [15:0] nextInstrPointer,
	output logic [15:0] stackTopPointer,
	// condition flags
	input wire cpurf_fop_type flagOp,
	input wire logic [7:0] flagImm,
	input wire logic bitAccWr,
	input wire logic bitAccVal,
	output logic [7:0] conditionFlags,
	output logic intMasked,
	output cpurf_cond_type branchCond,
	output logic bitAcc,
	output logic cpuReady
);

	////////////////////////////////////////////////////////////////////////////
	// helpers

	function automatic logic [15:0] readPair(input logic [7:0] hi, input logic [7:0] lo,
		input cpurf_size_type sz);
		if (sz == CPURF_SZ_WORD) begin
			return {hi, lo};
		end else if (sz == CPURF_SZ_HIGH) begin
			return {8'h00, hi};
		end else begin
			return {8'h00, lo};
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// state

	typedef enum {ST_VECTOR, ST_RUN, ST_ALU} cpurf_state_type;

	cpurf_state_type state_r, state_nxt;
	logic [7:0] gprHigh_r [8];
	logic [7:0] gprLow_r [8];
	logic [7:0] gprHigh_nxt [8];
	logic [7:0] gprLow_nxt [8];
	logic [15:0] pc_r, pc_nxt;
	logic [7:0] flags_r, flags_nxt;
	logic [3:0] cnt_r, cnt_nxt;
	cpurf_alu_req_type held_r, held_nxt;
	logic [15:0] res_r, res_nxt;
	logic done_r, done_nxt;

	////////////////////////////////////////////////////////////////////////////
	// alu on the held request

	logic [15:0] opA, opB, aluRes;
	logic [16:0] sum;
	logic [4:0] nibSum;
	logic [12:0] lowSum;
	logic isWord, isSub, carryIn, cOut, hOut, vOut, signBit;

	always_comb begin
		isWord = (held_r.size == CPURF_SZ_WORD);
		opA = readPair(gprHigh_r[held_r.dstIdx], gprLow_r[held_r.dstIdx], held_r.size);
		opB = held_r.useImm ? held_r.imm
			: readPair(gprHigh_r[held_r.srcIdx], gprLow_r[held_r.srcIdx], held_r.srcSize);
		if (held_r.op == CPURF_OP_NEG) begin
			opB = opA;
			opA = 16'h0000;
		end
		isSub = (held_r.op == CPURF_OP_SUB) || (held_r.op == CPURF_OP_SUBX)
			|| (held_r.op == CPURF_OP_CMP) || (held_r.op == CPURF_OP_NEG);
		carryIn = ((held_r.op == CPURF_OP_ADDX) || (held_r.op == CPURF_OP_SUBX))
			? flags_r[FLG_CARRY] : 1'b0;
		// subtraction as a + ~b + 1 - borrow; carry out inverted gives borrow
		if (isSub) begin
			sum = {1'b0, opA} + {1'b0, ~opB} + {16'h0000, ~carryIn};
			nibSum = {1'b0, opA[3:0]} + {1'b0, ~opB[3:0]} + {4'h0, ~carryIn};
			lowSum = {1'b0, opA[11:0]} + {1'b0, ~opB[11:0]} + {12'h000, ~carryIn};
		end else begin
			sum = {1'b0, opA} + {1'b0, opB} + {16'h0000, carryIn};
			nibSum = {1'b0, opA[3:0]} + {1'b0, opB[3:0]} + {4'h0, carryIn};
			lowSum = {1'b0, opA[11:0]} + {1'b0, opB[11:0]} + {12'h000, carryIn};
		end
		aluRes = isWord ? sum[15:0] : {8'h00, sum[7:0]};
		cOut = isWord ? sum[16] : (sum[8] ^ opA[8] ^ opB[8] ^ isSub);
		cOut = cOut ^ isSub;
		hOut = (isWord ? lowSum[12] : nibSum[4]) ^ isSub;
		signBit = isWord ? aluRes[15] : aluRes[7];
		vOut = isWord
			? ((opA[15] == (opB[15] ^ isSub)) && (aluRes[15] != opA[15]))
			: ((opA[7] == (opB[7] ^ isSub)) && (aluRes[7] != opA[7]));
		case (held_r.op)
			CPURF_OP_LOGIC, CPURF_OP_MOV: begin
				aluRes = isWord ? opB : {8'h00, opB[7:0]};
				cOut = flags_r[FLG_CARRY];
				hOut = flags_r[FLG_HALF];
				vOut = 1'b0;
			end
			CPURF_OP_SHL: begin
				aluRes = {8'h00, opA[6:0], 1'b0};
				cOut = opA[7];
				hOut = flags_r[FLG_HALF];
				vOut = 1'b0;
			end
			CPURF_OP_SHR: begin
				aluRes = {8'h00, 1'b0, opA[7:1]};
				cOut = opA[0];
				hOut = flags_r[FLG_HALF];
				vOut = 1'b0;
			end
			CPURF_OP_DAA, CPURF_OP_DAS: begin
				// packed decimal correction driven by half-carry and carry
				aluRes = {8'h00, opA[7:0]};
				cOut = flags_r[FLG_CARRY];
				if (flags_r[FLG_HALF] || (held_r.op == CPURF_OP_DAA && opA[3:0] > 4'h9)) begin
					aluRes[7:0] = (held_r.op == CPURF_OP_DAA) ? aluRes[7:0] + 8'h06
						: aluRes[7:0] - 8'h06;
				end
				if (flags_r[FLG_CARRY] || (held_r.op == CPURF_OP_DAA && opA[7:0] > 8'h99)) begin
					aluRes[7:0] = (held_r.op == CPURF_OP_DAA) ? aluRes[7:0] + 8'h60
						: aluRes[7:0] - 8'h60;
					cOut = (held_r.op == CPURF_OP_DAA) ? 1'b1 : flags_r[FLG_CARRY];
				end
				hOut = flags_r[FLG_HALF];
				vOut = flags_r[FLG_OVF];
			end
			default: begin
			end
		endcase
		signBit = isWord ? aluRes[15] : aluRes[7];
	end

	////////////////////////////////////////////////////////////////////////////
	// next state

	always_comb begin
		state_nxt = state_r;
		gprHigh_nxt = gprHigh_r;
		gprLow_nxt = gprLow_r;
		pc_nxt = pc_r;
		flags_nxt = flags_r;
		cnt_nxt = cnt_r;
		held_nxt = held_r;
		res_nxt = res_r;
		done_nxt = 1'b0;
		case (state_r)
			ST_VECTOR: begin
				if (vecValid) begin
					pc_nxt = vecData & WORD_EVEN_MASK;
					state_nxt = ST_RUN;
				end
			end
			ST_RUN: begin
				if (wrReq.valid) begin
					// byte writes touch one half only
					if (wrReq.size != CPURF_SZ_LOW) begin
						gprHigh_nxt[wrReq.idx] = (wrReq.size == CPURF_SZ_WORD)
							? wrReq.data[15:8] : wrReq.data[7:0];
					end
					if (wrReq.size != CPURF_SZ_HIGH) begin
						gprLow_nxt[wrReq.idx] = wrReq.data[7:0];
					end
				end
				if (aluReq.valid) begin
					held_nxt = aluReq;
					cnt_nxt = 4'(LATENCY - 1);
					state_nxt = ST_ALU;
				end
				// software flag ops
				case (flagOp)
					CPURF_FOP_LOAD: flags_nxt = flagImm;
					CPURF_FOP_AND: flags_nxt = flags_r & flagImm;
					CPURF_FOP_OR: flags_nxt = flags_r | flagImm;
					CPURF_FOP_XOR: flags_nxt = flags_r ^ flagImm;
					default: begin
					end
				endcase
				if (bitAccWr) begin
					flags_nxt[FLG_CARRY] = bitAccVal;
				end
				// stack pointer stepped by hardware
				if (excEntry || subCall) begin
					{gprHigh_nxt[STACK_PAIR], gprLow_nxt[STACK_PAIR]} =
						{gprHigh_r[STACK_PAIR], gprLow_r[STACK_PAIR]} - STACK_STEP;
				end else if (subRet) begin
					{gprHigh_nxt[STACK_PAIR], gprLow_nxt[STACK_PAIR]} =
						{gprHigh_r[STACK_PAIR], gprLow_r[STACK_PAIR]} + STACK_STEP;
				end
				if (excEntry) begin
					flags_nxt[FLG_IMASK] = 1'b1; // hardware set wins
				end
				if (pcLoad) begin
					pc_nxt = pcLoadVal & WORD_EVEN_MASK;
				end else if (pcStep) begin
					pc_nxt = pc_r + STACK_STEP;
				end
			end
			ST_ALU: begin
				if (cnt_r != 4'h0) begin
					cnt_nxt = cnt_r - 4'h1;
				end else begin
					state_nxt = ST_RUN;
					done_nxt = 1'b1;
					res_nxt = aluRes;
					flags_nxt[FLG_NEG] = signBit;
					flags_nxt[FLG_ZERO] = isWord ? (aluRes == 16'h0000)
						: (aluRes[7:0] == 8'h00);
					flags_nxt[FLG_OVF] = vOut;
					flags_nxt[FLG_CARRY] = cOut;
					flags_nxt[FLG_HALF] = hOut;
					if (held_r.op != CPURF_OP_CMP) begin
						if (held_r.size != CPURF_SZ_LOW) begin
							gprHigh_nxt[held_r.dstIdx] = isWord ? aluRes[15:8] : aluRes[7:0];
						end
						if (held_r.size != CPURF_SZ_HIGH) begin
							gprLow_nxt[held_r.dstIdx] = aluRes[7:0];
						end
					end
				end
			end
			default: state_nxt = ST_VECTOR;
		endcase
	end

	// general registers have no reset on purpose
	always_ff @(posedge sys_clk) begin
		gprHigh_r <= gprHigh_nxt;
		gprLow_r <= gprLow_nxt;
		held_r <= held_nxt;
		res_r <= res_nxt;
	end

	always_ff @(posedge sys_clk) begin
		if (rst) begin
			state_r <= ST_VECTOR;
			pc_r <= 16'h0000;
			flags_r <= FLAGS_RESET;
			cnt_r <= 4'h0;
			done_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			pc_r <= pc_nxt;
			flags_r <= flags_nxt;
			cnt_r <= cnt_nxt;
			done_r <= done_nxt;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// outputs

	assign vecReq = (state_r == ST_VECTOR);
	assign vecAddr = RESET_VECTOR_ADDR;
	assign aluBusy = (state_r != ST_RUN);
	assign aluDone = done_r;
	assign aluResult = res_r;
	assign rdData = readPair(gprHigh_r[rdIdx], gprLow_r[rdIdx], rdSize);
	assign addrOut = {gprHigh_r[addrIdx], gprLow_r[addrIdx]};
	assign nextInstrPointer = pc_r & WORD_EVEN_MASK;
	assign stackTopPointer = {gprHigh_r[STACK_PAIR], gprLow_r[STACK_PAIR]};
	assign conditionFlags = flags_r;
	assign intMasked = flags_r[FLG_IMASK];
	assign branchCond = '{flags_r[FLG_NEG], flags_r[FLG_ZERO], flags_r[FLG_OVF],
		flags_r[FLG_CARRY]};
	assign bitAcc = flags_r[FLG_CARRY];
	assign cpuReady = (state_r != ST_VECTOR);

endmodule

// File: tb/cpurf_monitor.sv
// cpurf_monitor: port relation checks for the register file and flags core.
// assumes it is bound to cpurf_core; sync active-high rst on sys_clk.
module cpurf_monitor
	import cpurf_pkg::*;
(
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// vector and alu
	input wire logic vecReq,
	input wire logic vecValid,
	input wire logic [15:0] vecData,
	input wire cpurf_alu_req_type aluReq,
	input wire logic aluBusy,
	input wire logic aluDone,
	input wire logic cpuReady,
	// stack, counter, flags
	input wire logic excEntry,
	input wire logic subCall,
	input wire logic subRet,
	input wire logic pcLoad,
	input wire logic pcStep,
	input wire logic [15:0] nextInstrPointer,
	input wire logic [15:0] stackTopPointer,
	input wire logic [7:0] conditionFlags,
	input wire logic intMasked,
	input wire cpurf_cond_type branchCond,
	input wire logic bitAcc
);
	timeunit 1ns;
	timeprecision 100ps;
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);
	////////////////////////////////////////////////////////////////////////////////
	property p_pcEven; nextInstrPointer[0] == 1'b0; endproperty
	a_pcEven: assert property (p_pcEven) else $error("odd instruction pointer");
	property p_maskView; intMasked == conditionFlags[FLG_IMASK]; endproperty
	a_maskView: assert property (p_maskView) else $error("mask output mismatch");
	property p_excMask; excEntry && !aluBusy |=> conditionFlags[FLG_IMASK]; endproperty
	a_excMask: assert property (p_excMask) else $error("mask not set on entry");
	// the stack pointer steps by a word on every implicit use taken while the core is not busy
	property p_stack;
		(excEntry || subCall || subRet) && !aluBusy |=> stackTopPointer ==
			$past(stackTopPointer) + ($past(subRet) ? STACK_STEP : 16'h0000 - STACK_STEP);
	endproperty
	a_stack: assert property (p_stack) else $error("stack step wrong");
	property p_branch; branchCond == conditionFlags[3:0]; endproperty
	a_branch: assert property (p_branch) else $error("branch conditions wrong");
	property p_bitAcc; bitAcc == conditionFlags[FLG_CARRY]; endproperty
	a_bitAcc: assert property (p_bitAcc) else $error("bit accumulator wrong");
	property p_aluLat; aluReq.valid && !aluBusy |=> aluBusy[*2] ##1 (aluDone && !aluBusy); endproperty
	a_aluLat: assert property (p_aluLat) else $error("alu latency wrong");
	property p_vec;
		vecReq && vecValid |=> cpuReady && !vecReq &&
			nextInstrPointer == ($past(vecData) & WORD_EVEN_MASK);
	endproperty
	a_vec: assert property (p_vec) else $error("vector not loaded");
	property p_preReady; !cpuReady |-> vecReq && conditionFlags[FLG_IMASK]; endproperty
	a_preReady: assert property (p_preReady) else $error("wait state wrong");
	property p_pcStep;
		pcStep && !pcLoad && !aluBusy |=> nextInstrPointer == $past(nextInstrPointer) + 16'h0002;
	endproperty
	a_pcStep: assert property (p_pcStep) else $error("counter step wrong");
	c_vec: cover property (vecReq && vecValid);
	c_alu: cover property (aluDone);
	c_stack: cover property (excEntry && !aluBusy);
endmodule

bind cpurf_core cpurf_monitor u_monitor (.sys_clk, .rst, .vecReq, .vecValid, .vecData, .aluReq,
	.aluBusy, .aluDone, .cpuReady, .excEntry, .subCall, .subRet, .pcLoad, .pcStep,
	.nextInstrPointer, .stackTopPointer, .conditionFlags, .intMasked, .branchCond, .bitAcc);

// File: tb/cpurf_vec_src.sv
// cpurf_vec_src: memory word behind the reset vector fetch.
// assumes vecReq is a level held until taken; answers a fixed count of cycles late.
module cpurf_vec_src
#(
	parameter logic [15:0] VECTOR = 16'h0100,
	parameter int WAIT = 3
) (
	// clock and reset
	input wire logic sys_clk,
	input wire logic rst,
	// vector fetch
	input wire logic vecReq,
	input wire logic [15:0] vecAddr,
	output logic vecValid,
	output logic [15:0] vecData
);
	timeunit 1ns;
	timeprecision 100ps;
	int cnt;
	always @(posedge sys_clk) begin
		if (rst || !vecReq) cnt <= 0;
		else if (cnt < WAIT) cnt <= cnt + 1;
	end
	assign vecValid = vecReq && !rst && cnt == WAIT;
	// junk off the answer so a stale word is never taken
	assign vecData = (vecValid && vecAddr == 16'h0000) ? VECTOR : ~VECTOR ^ 16'(cnt);
endmodule

// File: tb/cpu_register_file_and_flags_tb.sv
// cpu_register_file_and_flags_tb: self-checking bench for cpurf_core.
// assumes cpurf_monitor bound and cpurf_vec_src as the vector memory.
module cpu_register_file_and_flags_tb
	import cpurf_pkg::*;
;
	timeunit 1ns;
	timeprecision 100ps;
	localparam logic [15:0] VEC = 16'h1235;
	logic sys_clk = '0, rst = 1'b1, excEntry = '0, subCall = '0, subRet = '0;
	logic pcLoad = '0, pcStep = '0, bitAccWr = '0, bitAccVal = '0;
	logic vecReq, vecValid, aluBusy, aluDone, intMasked, bitAcc, cpuReady;
	logic [15:0] vecAddr, vecData, aluResult, rdData, addrOut, nextInstrPointer, stackTopPointer;
	logic [15:0] pcLoadVal = '0;
	logic [2:0] rdIdx = '0, addrIdx = '0;
	cpurf_size_type rdSize = CPURF_SZ_WORD;
	cpurf_alu_req_type aluReq = '0;
	cpurf_wr_req_type wrReq = '0;
	cpurf_fop_type flagOp = CPURF_FOP_NONE;
	logic [7:0] flagImm = '0, conditionFlags, mf;
	cpurf_cond_type branchCond;
	logic [15:0] mr [8];
	cpurf_op_type xop [7] = '{CPURF_OP_ADDX, CPURF_OP_SUBX, CPURF_OP_NEG, CPURF_OP_SHL,
		CPURF_OP_SHR, CPURF_OP_DAA, CPURF_OP_DAS};
	int numErrors = 0, checksDone = 0, seed = 32'h0d2169ae;
	always #2.5 sys_clk = ~sys_clk;
	cpurf_core #(.LATENCY(2)) DUT (.sys_clk, .rst, .vecReq, .vecAddr, .vecValid, .vecData,
		.aluReq, .aluBusy, .aluDone, .aluResult, .wrReq, .rdIdx, .rdSize, .rdData, .addrIdx,
		.addrOut, .excEntry, .subCall, .subRet, .pcLoad, .pcLoadVal, .pcStep, .nextInstrPointer,
		.stackTopPointer, .flagOp, .flagImm, .bitAccWr, .bitAccVal, .conditionFlags, .intMasked,
		.branchCond, .bitAcc, .cpuReady);
	cpurf_vec_src #(.VECTOR(VEC), .WAIT(3)) u_vec (.sys_clk, .rst, .vecReq, .vecAddr, .vecValid,
		.vecData);
	////////////////////////////////////////////////////////////////////////////////
	task automatic step(); @(posedge sys_clk); #1; endtask
	task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
		checksDone++;
		if (seen !== exp) begin
			numErrors++;
			$display("Error at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task automatic conclude();
		if (numErrors == 0 && checksDone > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask
	function automatic logic [15:0] mget(input logic [2:0] i, input cpurf_size_type s);
		if (s == CPURF_SZ_HIGH) return {8'h00, mr[i][15:8]};
		if (s == CPURF_SZ_LOW) return {8'h00, mr[i][7:0]};
		return mr[i];
	endfunction
	task automatic mset(input logic [2:0] i, input cpurf_size_type s, input logic [15:0] v);
		if (s == CPURF_SZ_HIGH) mr[i][15:8] = v[7:0];
		else if (s == CPURF_SZ_LOW) mr[i][7:0] = v[7:0];
		else mr[i] = v;
	endtask
	task automatic cmpall();
		for (int i = 0; i < 8; i++) begin
			for (int s = 0; s < 3; s++) begin
				rdIdx = 3'(i);
				addrIdx = 3'(i);
				rdSize = cpurf_size_type'(2'(s));
				step();
				chk(rdData, mget(3'(i), rdSize));
			end
			chk(addrOut, mr[i]);
		end
		chk(stackTopPointer, mr[7]);
		chk(16'(conditionFlags), 16'(mf));
		chk(16'(branchCond), 16'(mf[3:0]));
		chk(16'(intMasked), 16'(mf[7]));
	endtask
	task automatic wr(input logic [2:0] i, input cpurf_size_type s, input logic [15:0] v);
		wrReq = '{1'b1, s, i, v};
		step();
		wrReq.valid = 1'b0;
		mset(i, s, v);
		step();
	endtask
	task automatic fop(input cpurf_fop_type op, input logic [7:0] v);
		flagOp = op;
		flagImm = v;
		step();
		flagOp = CPURF_FOP_NONE;
		case (op)
			CPURF_FOP_LOAD: mf = v;
			CPURF_FOP_AND: mf &= v;
			CPURF_FOP_OR: mf |= v;
			default: mf ^= v;
		endcase
	endtask
	task automatic alu(input cpurf_op_type op, input cpurf_size_type sz, input logic [2:0] d,
		input logic [2:0] s);
		int a, b, r, w, m, h, k, ci;
		cpurf_size_type ss;
		ss = (sz == CPURF_SZ_WORD) ? sz : (s[0] ? CPURF_SZ_HIGH : CPURF_SZ_LOW);
		w = (sz == CPURF_SZ_WORD) ? 16 : 8;
		m = (1 << w) - 1;
		h = (w == 16) ? 'hfff : 'hf;
		a = mget(d, sz);
		b = mget(s, ss);
		aluReq = '{1'b1, op, sz, d, s, ss, 1'b0, 16'h0000};
		step();
		aluReq.valid = 1'b0;
		for (k = 0; k < 8 && aluDone !== 1'b1; k++) step();
		chk(16'(k), 16'h0002);
		ci = (op == CPURF_OP_ADDX || op == CPURF_OP_SUBX) ? int'(mf[0]) : 0;
		if (op == CPURF_OP_NEG) begin
			b = a;
			a = 0;
		end
		if (op == CPURF_OP_ADD || op == CPURF_OP_ADDX) begin
			r = a + b + ci;
			mf[5] = ((a & h) + (b & h) + ci) > h;
			mf[1] = 1'(((a ^ r) & ~(a ^ b)) >> (w - 1));
			mf[0] = 1'(r >> w);
		end else if (op == CPURF_OP_SHL || op == CPURF_OP_SHR) begin
			// byte shifts: carry takes the bit pushed out, overflow cleared
			r = (op == CPURF_OP_SHL) ? a << 1 : a >> 1;
			mf[0] = (op == CPURF_OP_SHL) ? a[7] : a[0];
			mf[1] = 1'b0;
		end else if (op == CPURF_OP_DAA || op == CPURF_OP_DAS) begin
			// reads half-carry and carry; half-carry and overflow stay as they were
			r = a;
			if (mf[5] || (op == CPURF_OP_DAA && (a & 'hf) > 9)) begin
				r = (op == CPURF_OP_DAA) ? r + 'h6 : r - 'h6;
			end
			if (mf[0] || (op == CPURF_OP_DAA && a > 'h99)) begin
				r = (op == CPURF_OP_DAA) ? r + 'h60 : r - 'h60;
				mf[0] = mf[0] | (op == CPURF_OP_DAA);
			end
		end else begin
			r = a - b - ci;
			mf[5] = (a & h) < (b & h) + ci;
			mf[1] = 1'(((a ^ r) & (a ^ b)) >> (w - 1));
			mf[0] = 1'(r >> w);
		end
		r &= m;
		mf[3] = 1'(r >> (w - 1));
		mf[2] = r == 0;
		if (op != CPURF_OP_CMP) begin
			mset(d, sz, 16'(r));
			chk(aluResult, 16'(r));
		end
		cmpall();
	endtask
	task automatic do_reset();
		rst = 1'b1;
		repeat (10) step();
		chk(16'(conditionFlags[7]), 16'h0001);
		chk(16'(cpuReady), 16'h0000);
		rst = 1'b0;
		for (int k = 0; k < 20 && cpuReady !== 1'b1; k++) step();
		chk(nextInstrPointer, VEC & 16'hfffe);
		chk(vecAddr, 16'h0000);
		fop(CPURF_FOP_LOAD, 8'h80);
	endtask
	////////////////////////////////////////////////////////////////////////////////
	initial begin
		do_reset();
		for (int i = 0; i < 8; i++) wr(3'(i), CPURF_SZ_WORD, 16'($random(seed)));
		cmpall();
		for (int i = 0; i < 12; i++) begin
			wr(3'($random(seed)), i[0] ? CPURF_SZ_HIGH : CPURF_SZ_LOW, 16'($random(seed)));
			cmpall();
		end
		for (int i = 0; i < 16; i++) begin
			fop(cpurf_fop_type'(3'(1 + i % 4)), 8'($random(seed)));
			cmpall();
		end
		for (int i = 0; i < 2; i++) begin
			bitAccWr = 1'b1;
			bitAccVal = i[0];
			step();
			bitAccWr = 1'b0;
			mf[0] = i[0];
			chk(16'(bitAcc), 16'(i[0]));
			cmpall();
		end
		// boundary sums: zero with carry and overflow, then a negative sum with no carry out of bit 11
		wr(3'h1, CPURF_SZ_WORD, 16'h8000);
		wr(3'h2, CPURF_SZ_WORD, 16'h8000);
		alu(CPURF_OP_ADD, CPURF_SZ_WORD, 3'h1, 3'h2);
		wr(3'h3, CPURF_SZ_WORD, 16'h0fff);
		alu(CPURF_OP_ADD, CPURF_SZ_WORD, 3'h3, 3'h2);
		// packed decimal 38 + 49 gives 81 with half-carry, adjusted to 87
		wr(3'h4, CPURF_SZ_WORD, 16'h0038);
		wr(3'h5, CPURF_SZ_WORD, 16'h4900);
		alu(CPURF_OP_ADD, CPURF_SZ_LOW, 3'h4, 3'h5);
		alu(CPURF_OP_DAA, CPURF_SZ_LOW, 3'h4, 3'h4);
		chk(aluResult, 16'h0087);
		for (int i = 0; i < 27; i++) begin
			alu(cpurf_op_type'(4'(1 + 2 * (i % 3))), cpurf_size_type'(2'((i / 3) % 3)),
				3'($random(seed)), 3'($random(seed)));
		end
		// carry-in, negate, shift and decimal adjust on byte halves
		for (int i = 0; i < 14; i++) begin
			alu(xop[i % 7], i[0] ? CPURF_SZ_HIGH : CPURF_SZ_LOW, 3'($random(seed)),
				3'($random(seed)));
		end
		wr(3'h7, CPURF_SZ_WORD, 16'h4000);
		fop(CPURF_FOP_AND, 8'h7f);
		for (int i = 0; i < 3; i++) begin
			excEntry = i == 0;
			subCall = i == 1;
			subRet = i == 2;
			step();
			{excEntry, subCall, subRet} = '0;
			mr[7] = (i == 2) ? mr[7] + 16'h0002 : mr[7] - 16'h0002;
			if (i == 0) mf[7] = 1'b1;
			cmpall();
		end
		pcLoadVal = 16'h2a5b;
		pcLoad = 1'b1;
		pcStep = 1'b1;
		step();
		pcLoad = 1'b0;
		chk(nextInstrPointer, 16'h2a5a);
		step();
		pcStep = 1'b0;
		chk(nextInstrPointer, 16'h2a5c);
		do_reset();
		conclude();
	end
	initial begin
		#30000;
		numErrors++;
		conclude();
	end
endmodule
